/* File: design/asfr_cfg.svh */
`ifndef ASFR_CFG_SVH
`define ASFR_CFG_SVH

// Register indices on the bus; byte address is four times the index
`define ASFR_IDX_W       2'h0
`define ASFR_IDX_STATUS  2'h3
`define ASFR_IDX_LSB     2
`define ASFR_IDX_MSB     3

// Status register field positions
`define ASFR_B_IND       7
`define ASFR_B_RP_HI     6
`define ASFR_B_RP_LO     5
`define ASFR_B_TO        4
`define ASFR_B_PD        3
`define ASFR_B_Z         2
`define ASFR_B_DC        1
`define ASFR_B_C         0

// Reset and write masks
`define ASFR_STATUS_RST  8'h18
`define ASFR_W_RST       8'h00
`define ASFR_WR_MASK     8'hE7
`define ASFR_FLAG_MASK   8'h07
`define ASFR_BANK_MASK   8'hE0
`define ASFR_STATUS_FILE 7'h03
`define ASFR_ZERO8       8'h00
`define ASFR_ONES8       8'hFF

// Opcode fields
`define ASFR_OP5_LITERAL_ADD_INSTR   5'h1F
`define ASFR_OP5_SUBTRACT_FROM_LITERAL_INSTR   5'h1E
`define ASFR_OP6_LITERAL_AND_INSTR   6'h39
`define ASFR_OP6_ADDWF   6'h07
`define ASFR_OP6_SUBTRACT_WORK_FROM_FILE_INSTR   6'h02
`define ASFR_OP6_ANDWF   6'h05
`define ASFR_OP6_NIBBLE_SWAP_INSTR   6'h0E
`define ASFR_OP7_CLEAR_FILE_INSTR    7'h03
`define ASFR_OP7_MOVE_WORK_TO_FILE_INSTR   7'h01
`define ASFR_OP4_BCF     4'h4
`define ASFR_OP4_BSF     4'h5
`define ASFR_WORD_WATCHDOG_CLEAR_INSTR 14'h0064
`define ASFR_WORD_SLEEP  14'h0063
`define ASFR_D_BIT       7
`define ASFR_NIB_MSB     4

`endif

/* File: design/asfr_pkg.sv */
package asfr_pkg;
  `include "asfr_cfg.svh"

  typedef enum {
    ASFR_NOP, ASFR_LITERAL_ADD_INSTR, ASFR_SUBTRACT_FROM_LITERAL_INSTR, ASFR_LITERAL_AND_INSTR, ASFR_ADDWF,
    ASFR_SUBTRACT_WORK_FROM_FILE_INSTR, ASFR_ANDWF, ASFR_NIBBLE_SWAP_INSTR, ASFR_CLEAR_FILE_INSTR, ASFR_MOVE_WORK_TO_FILE_INSTR,
    ASFR_BCF, ASFR_BSF, ASFR_WATCHDOG_CLEAR_INSTR, ASFR_SLEEP
  } asfr_op_e;

  typedef logic [7:0] asfr_byte_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  w;
    logic        wr_en;
    logic [8:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wdt_clear;
    logic        sleep_go;
    logic [31:0] rdata;
    logic        waitreq;
  } asfr_state_s;
endpackage : asfr_pkg

/* File: design/asfr_status_core.sv */
// Operation
// - A flag-setting instruction aimed at the status register takes its updated flags from the ALU result, keeps the other flags, and writes only the bank bits.
// - Instruction and bus writes never change the time-out or power-down bits.
// - Clearing the status register zeroes the bank bits, sets Z and keeps time-out, power-down, DC and C.
// - Bit clear, bit set, nibble swap and move-from-W write Z, C and DC of the status register from the written value, like the bank bits.
// - In subtraction C and DC read one when no borrow and no digit borrow occurred.
// - The indirect bank bit selects banks 2 and 3 when one and banks 0 and 1 when zero.
// - The two direct bank bits select bank 0 to 3 at 00h, 80h, 100h and 180h.
// - Time-out is one after reset, watchdog clear or sleep, and zero after a watchdog expiry.
// - Power-down is one after reset or watchdog clear and zero after sleep.
// - Z is one when an arithmetic or logic result is zero and zero otherwise.
// - DC reports carry out of the low nibble on add, inverted for borrow on subtract.
// - C reports carry out of the top bit, with subtraction done as addition of the two's complement.
// - Literal AND puts W and the literal into W and updates only Z.
`timescale 1ns/1ns
`include "asfr_cfg.svh"
module asfr_status_core
  import asfr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Instruction stream from the core
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  input  wire logic [7:0]  file_rdata,
  input  wire logic        wdt_expire,
  // Data memory write port
  output logic             file_wr_en,
  output logic [8:0]       file_wr_addr,
  output logic [7:0]       file_wr_data,
  // Status and watchdog side effects
  output logic [7:0]       status_out,
  output logic [7:0]       w_out,
  output logic             indirect_bank_bit,
  output logic             wdt_clear,
  output logic             sleep_go,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import asfr_pkg::*;

  asfr_state_s state;
  asfr_state_s next_state;

  function automatic asfr_op_e decode(input logic [13:0] iw);
    asfr_op_e op;
    op = ASFR_NOP;
    if (iw[13:9] == `ASFR_OP5_LITERAL_ADD_INSTR)       op = ASFR_LITERAL_ADD_INSTR;
    else if (iw[13:9] == `ASFR_OP5_SUBTRACT_FROM_LITERAL_INSTR)  op = ASFR_SUBTRACT_FROM_LITERAL_INSTR;
    else if (iw[13:8] == `ASFR_OP6_LITERAL_AND_INSTR)  op = ASFR_LITERAL_AND_INSTR;
    else if (iw[13:8] == `ASFR_OP6_ADDWF)  op = ASFR_ADDWF;
    else if (iw[13:8] == `ASFR_OP6_SUBTRACT_WORK_FROM_FILE_INSTR)  op = ASFR_SUBTRACT_WORK_FROM_FILE_INSTR;
    else if (iw[13:8] == `ASFR_OP6_ANDWF)  op = ASFR_ANDWF;
    else if (iw[13:8] == `ASFR_OP6_NIBBLE_SWAP_INSTR)  op = ASFR_NIBBLE_SWAP_INSTR;
    else if (iw[13:7] == `ASFR_OP7_CLEAR_FILE_INSTR)   op = ASFR_CLEAR_FILE_INSTR;
    else if (iw[13:7] == `ASFR_OP7_MOVE_WORK_TO_FILE_INSTR)  op = ASFR_MOVE_WORK_TO_FILE_INSTR;
    else if (iw[13:10] == `ASFR_OP4_BCF)   op = ASFR_BCF;
    else if (iw[13:10] == `ASFR_OP4_BSF)   op = ASFR_BSF;
    else if (iw == `ASFR_WORD_WATCHDOG_CLEAR_INSTR)      op = ASFR_WATCHDOG_CLEAR_INSTR;
    else if (iw == `ASFR_WORD_SLEEP)       op = ASFR_SLEEP;
    return op;
  endfunction : decode

  // Status is mirrored in every bank, so the bank bits are not compared
  function automatic logic is_status(input logic [6:0] f);
    return f == `ASFR_STATUS_FILE;
  endfunction : is_status

  // Sum with carry in; returns {dc, c, result}
  function automatic logic [9:0] alu_add(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {low[`ASFR_NIB_MSB], full};
  endfunction : alu_add

  asfr_op_e   op;
  logic [6:0] f_field;
  logic       dest_f;
  logic [7:0] f_val;
  logic [7:0] lit;
  logic [1:0] bus_idx;

  assign op      = decode(instr_word);
  assign f_field = instr_word[6:0];
  assign dest_f  = instr_word[`ASFR_D_BIT];
  assign lit     = instr_word[7:0];
  assign f_val   = is_status(f_field) ? state.status : file_rdata;
  assign bus_idx = avs_address[`ASFR_IDX_MSB:`ASFR_IDX_LSB];

  always_comb begin
    logic [7:0] st;
    logic [7:0] res;
    logic [9:0] sum;
    logic       to_w;
    logic       to_f;
    logic       upd_z;
    logic       upd_cdc;
    st      = state.status;
    res     = `ASFR_ZERO8;
    sum     = {2'b00, `ASFR_ZERO8};
    to_w    = 1'b0;
    to_f    = 1'b0;
    upd_z   = 1'b0;
    upd_cdc = 1'b0;
    next_state           = state;
    next_state.wr_en     = 1'b0;
    next_state.wdt_clear = 1'b0;
    next_state.sleep_go  = 1'b0;

    // Bus write lands first; an instruction in the same cycle writes over it but takes its operands from the old W and status
    if (avs_write && !state.waitreq && bus_idx == `ASFR_IDX_STATUS) begin
      st = (st & ~`ASFR_WR_MASK) |
           (avs_writedata[7:0] & `ASFR_WR_MASK);
    end
    if (avs_write && !state.waitreq && bus_idx == `ASFR_IDX_W) begin
      next_state.w = avs_writedata[7:0];
    end

    if (instr_valid) begin
      case (op)
        ASFR_LITERAL_ADD_INSTR: begin
          sum     = alu_add(state.w, lit, 1'b0);
          res     = sum[7:0];
          to_w    = 1'b1;
          upd_z   = 1'b1;
          upd_cdc = 1'b1;
        end
        ASFR_SUBTRACT_FROM_LITERAL_INSTR: begin
          sum     = alu_add(lit, ~state.w, 1'b1);
          res     = sum[7:0];
          to_w    = 1'b1;
          upd_z   = 1'b1;
          upd_cdc = 1'b1;
        end
        ASFR_LITERAL_AND_INSTR: begin
          res   = state.w & lit;
          to_w  = 1'b1;
          upd_z = 1'b1;
        end
        ASFR_ADDWF: begin
          sum     = alu_add(f_val, state.w, 1'b0);
          res     = sum[7:0];
          to_w    = !dest_f;
          to_f    = dest_f;
          upd_z   = 1'b1;
          upd_cdc = 1'b1;
        end
        ASFR_SUBTRACT_WORK_FROM_FILE_INSTR: begin
          // Two's complement add, so carry out means no borrow
          sum     = alu_add(f_val, ~state.w, 1'b1);
          res     = sum[7:0];
          to_w    = !dest_f;
          to_f    = dest_f;
          upd_z   = 1'b1;
          upd_cdc = 1'b1;
        end
        ASFR_ANDWF: begin
          res   = f_val & state.w;
          to_w  = !dest_f;
          to_f  = dest_f;
          upd_z = 1'b1;
        end
        ASFR_NIBBLE_SWAP_INSTR: begin
          res  = {f_val[3:0], f_val[7:4]};
          to_w = !dest_f;
          to_f = dest_f;
        end
        ASFR_CLEAR_FILE_INSTR: begin
          res   = `ASFR_ZERO8;
          to_f  = 1'b1;
          upd_z = 1'b1;
        end
        ASFR_MOVE_WORK_TO_FILE_INSTR: begin
          res  = state.w;
          to_f = 1'b1;
        end
        ASFR_BCF: begin
          res = f_val & ~(8'h01 << instr_word[9:7]);
          to_f = 1'b1;
        end
        ASFR_BSF: begin
          res = f_val | (8'h01 << instr_word[9:7]);
          to_f = 1'b1;
        end
        ASFR_WATCHDOG_CLEAR_INSTR: begin
          st[`ASFR_B_TO] = 1'b1;
          st[`ASFR_B_PD] = 1'b1;
          next_state.wdt_clear = 1'b1;
        end
        ASFR_SLEEP: begin
          st[`ASFR_B_TO] = 1'b1;
          st[`ASFR_B_PD] = 1'b0;
          next_state.sleep_go = 1'b1;
        end
        default: begin
          res = `ASFR_ZERO8;
        end
      endcase

      if (to_w) begin
        next_state.w = res;
      end
      if (to_f && is_status(f_field)) begin
        // Timer bits never written; flags only when the ALU owns none of them
        st = (st & ~`ASFR_BANK_MASK) | (res & `ASFR_BANK_MASK);
        if (!upd_z && !upd_cdc) begin
          st = (st & ~`ASFR_FLAG_MASK) |
               (res & `ASFR_FLAG_MASK);
        end
      end else if (to_f) begin
        next_state.wr_en   = 1'b1;
        next_state.wr_addr = {st[`ASFR_B_RP_HI:`ASFR_B_RP_LO],
                              f_field};
        next_state.wr_data = res;
      end
      // Flag update overrides any written value
      if (upd_z) begin
        st[`ASFR_B_Z] = (res == `ASFR_ZERO8);
      end
      if (upd_cdc) begin
        st[`ASFR_B_C]  = sum[8];
        st[`ASFR_B_DC] = sum[9];
      end
    end

    // Expiry wins over a clear in the same cycle so it is not lost
    if (wdt_expire) begin
      st[`ASFR_B_TO] = 1'b0;
    end
    next_state.status = st;

    // One cycle answer: waitrequest drops for exactly one edge
    next_state.waitreq = 1'b1;
    if ((avs_read || avs_write) && state.waitreq) begin
      next_state.waitreq = 1'b0;
      next_state.rdata   = 32'h0000_0000;
      if (avs_read && bus_idx == `ASFR_IDX_STATUS) begin
        next_state.rdata = {24'h00_0000, state.status};
      end else if (avs_read && bus_idx == `ASFR_IDX_W) begin
        next_state.rdata = {24'h00_0000, state.w};
      end
    end

    if (rst) begin
      next_state         = '0;
      next_state.status  = `ASFR_STATUS_RST;
      next_state.w       = `ASFR_W_RST;
      next_state.waitreq = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  assign file_wr_en        = state.wr_en;
  assign file_wr_addr      = state.wr_addr;
  assign file_wr_data      = state.wr_data;
  assign status_out        = state.status;
  assign w_out             = state.w;
  // Upper bit of a 9-bit indirect address: banks 2 and 3 from 100h
  assign indirect_bank_bit = state.status[`ASFR_B_IND];
  assign wdt_clear         = state.wdt_clear;
  assign sleep_go          = state.sleep_go;
  assign avs_readdata      = state.rdata;
  assign avs_waitrequest   = state.waitreq;

  // Checks
  logic inst_ok;
  assign inst_ok = instr_valid && !wdt_expire && !avs_write;

  a_status_flags_kept: assert property (
    @(posedge sys_clk) disable iff (rst)
    inst_ok && !is_status(f_field) &&
    (op == ASFR_MOVE_WORK_TO_FILE_INSTR || op == ASFR_BSF || op == ASFR_BCF ||
     op == ASFR_NIBBLE_SWAP_INSTR)
    |=> status_out[2:0] == $past(status_out[2:0]))
    else $error("status flags changed by a non-flag instruction");

  a_timer_bits_held: assert property (
    @(posedge sys_clk) disable iff (rst)
    instr_valid && !wdt_expire && op != ASFR_WATCHDOG_CLEAR_INSTR && op != ASFR_SLEEP
    |=> status_out[4:3] == $past(status_out[4:3]))
    else $error("time-out or power-down changed by a write");

  a_clear_status: assert property (
    @(posedge sys_clk) disable iff (rst)
    inst_ok && op == ASFR_CLEAR_FILE_INSTR && is_status(f_field)
    |=> status_out[7:5] == 3'h0 && status_out[`ASFR_B_Z] &&
        status_out[4:3] == $past(status_out[4:3]) &&
        status_out[1:0] == $past(status_out[1:0]))
    else $error("clear of status gave wrong value");

  a_sub_no_borrow: assert property (
    @(posedge sys_clk) disable iff (rst)
    inst_ok && op == ASFR_SUBTRACT_FROM_LITERAL_INSTR
    |=> status_out[`ASFR_B_C] == ($past(lit) >= $past(w_out)) &&
        status_out[`ASFR_B_DC] == ($past(lit[3:0]) >= $past(w_out[3:0])))
    else $error("borrow polarity wrong in subtraction");

  a_direct_bank_addr: assert property (
    @(posedge sys_clk) disable iff (rst)
    inst_ok && op == ASFR_MOVE_WORK_TO_FILE_INSTR && !is_status(f_field)
    |=> file_wr_en && file_wr_addr == {$past(status_out[6:5]),
                                       $past(f_field)})
    else $error("direct address not formed from bank bits");

  a_bank_select: assert property (
    @(posedge sys_clk) disable iff (rst)
    file_wr_en |-> file_wr_addr[8:7] == $past(status_out[6:5]))
    else $error("direct bank field not used for address");

  // A status write by the bus must reach the indirect bank output
  a_indirect_bank: assert property (
    @(posedge sys_clk) disable iff (rst)
    avs_write && !avs_waitrequest && bus_idx == `ASFR_IDX_STATUS &&
    !instr_valid
    |=> indirect_bank_bit == $past(avs_writedata[`ASFR_B_IND]))
    else $error("indirect bank bit does not follow a status write");

  a_timeout_expiry: assert property (
    @(posedge sys_clk) disable iff (rst)
    wdt_expire |=> !status_out[`ASFR_B_TO])
    else $error("time-out not cleared by watchdog expiry");

  a_sleep_powerdown: assert property (
    @(posedge sys_clk) disable iff (rst)
    instr_valid && op == ASFR_SLEEP && !wdt_expire
    |=> !status_out[`ASFR_B_PD] && status_out[`ASFR_B_TO] && sleep_go)
    else $error("sleep did not set time-out and clear power-down");

  a_zero_flag: assert property (
    @(posedge sys_clk) disable iff (rst)
    inst_ok && op == ASFR_LITERAL_AND_INSTR
    |=> status_out[`ASFR_B_Z] == (w_out == 8'h00) &&
        w_out == ($past(w_out) & $past(lit)) &&
        status_out[1:0] == $past(status_out[1:0]))
    else $error("literal AND result or zero flag wrong");

  a_add_flags: assert property (
    @(posedge sys_clk) disable iff (rst)
    inst_ok && op == ASFR_LITERAL_ADD_INSTR
    |=> w_out == 8'($past(w_out) + $past(lit)) &&
        status_out[`ASFR_B_C] == (9'($past(w_out)) + 9'($past(lit)) > 9'hFF)
        && status_out[`ASFR_B_Z] == (w_out == 8'h00))
    else $error("literal add result or flags wrong");

  a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write)
    |-> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule : asfr_status_core

/* File: verif/asfr_status_core_tb_top.sv */
`timescale 1ns/1ns
module asfr_status_core_tb_top;
  import asfr_pkg::*;

  logic        sys_clk;
  logic        rst;
  logic        instr_valid;
  logic [13:0] instr_word;
  logic [7:0]  file_rdata;
  logic        wdt_expire;
  logic        file_wr_en;
  logic [8:0]  file_wr_addr;
  logic [7:0]  file_wr_data;
  logic [7:0]  status_out;
  logic [7:0]  w_out;
  logic        indirect_bank_bit;
  logic        wdt_clear;
  logic        sleep_go;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rd;
  int          n_mismatch;
  int          n_checks;
  int          cycles;

  asfr_status_core i_asfr_status_core (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .instr_valid       (instr_valid),
    .instr_word        (instr_word),
    .file_rdata        (file_rdata),
    .wdt_expire        (wdt_expire),
    .file_wr_en        (file_wr_en),
    .file_wr_addr      (file_wr_addr),
    .file_wr_data      (file_wr_data),
    .status_out        (status_out),
    .w_out             (w_out),
    .indirect_bank_bit (indirect_bank_bit),
    .wdt_clear         (wdt_clear),
    .sleep_go          (sleep_go),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // A whole run needs under a hundred cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Master holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] addr,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge sys_clk);
    avs_address   <= addr;
    avs_writedata <= wdata;
    avs_write     <= wr;
    avs_read      <= ~wr;
    // Only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // One instruction; results are looked at in the cycle after it
  task automatic exec(input logic [13:0] word, input logic [7:0] exp_w,
                      input logic [7:0] exp_st);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word  <= word;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk("w_out", {24'h00_0000, exp_w}, {24'h00_0000, w_out});
    chk("status_out", {24'h00_0000, exp_st}, {24'h00_0000, status_out});
  endtask : exec

  task automatic expire();
    @(posedge sys_clk);
    wdt_expire <= 1'b1;
    @(posedge sys_clk);
    wdt_expire <= 1'b0;
    #1;
  endtask : expire

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    file_rdata = 8'h00;
    wdt_expire = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    n_mismatch = 0;
    n_checks = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("status after reset", 32'h0000_0018, {24'h00_0000, status_out});
    bus(1'b0, 4'hc, 32'h0000_0000, rd);
    chk("status read", 32'h0000_0018, rd);
    bus(1'b1, 4'h4, 32'h0000_00ff, rd);
    bus(1'b0, 4'h4, 32'h0000_0000, rd);
    chk("unmapped read", 32'h0000_0000, rd);
    $display("test reset done");

    exec(14'h3e0f, 8'h0f, 8'h18);
    exec(14'h3e01, 8'h10, 8'h1a);
    exec(14'h3ef0, 8'h00, 8'h1d);
    $display("test add done");

    exec(14'h3e02, 8'h02, 8'h18);
    exec(14'h3c01, 8'hff, 8'h18);
    exec(14'h3cff, 8'h00, 8'h1f);
    bus(1'b1, 4'h0, 32'h0000_0002, rd);
    file_rdata <= 8'h03;
    exec(14'h02a0, 8'h02, 8'h1b);
    chk("file_wr_en", 32'h1, {31'h0, file_wr_en});
    chk("file_wr_addr", 32'h0000_0020, {23'h0, file_wr_addr});
    chk("file_wr_data", 32'h0000_0001, {24'h00_0000, file_wr_data});
    @(posedge sys_clk);
    file_rdata <= 8'h01;
    exec(14'h0220, 8'hff, 8'h18);
    $display("test subtract done");

    exec(14'h3e01, 8'h00, 8'h1f);
    bus(1'b1, 4'h0, 32'h0000_00a3, rd);
    exec(14'h395f, 8'h03, 8'h1b);
    $display("test and done");

    // Bus write tries to clear the reset-cause bits as well
    bus(1'b1, 4'hc, 32'h0000_00e4, rd);
    bus(1'b0, 4'hc, 32'h0000_0000, rd);
    chk("status write", 32'h0000_00fc, rd);
    chk("indirect bank", 32'h1, {31'h0, indirect_bank_bit});
    file_rdata <= 8'h10;
    exec(14'h0285, 8'h03, 8'hf9);
    chk("file_wr_addr", 32'h0000_0185, {23'h0, file_wr_addr});
    chk("file_wr_data", 32'h0000_000d, {24'h00_0000, file_wr_data});
    exec(14'h0183, 8'h03, 8'h1d);
    chk("no file write", 32'h0, {31'h0, file_wr_en});
    chk("indirect bank", 32'h0, {31'h0, indirect_bank_bit});
    exec(14'h0783, 8'h03, 8'h3a);
    exec(14'h0083, 8'h03, 8'h1b);
    exec(14'h1783, 8'h03, 8'h9b);
    exec(14'h1003, 8'h03, 8'h9a);
    exec(14'h1203, 8'h03, 8'h9a);
    exec(14'h0e83, 8'h03, 8'hb9);
    $display("test status target done");

    expire();
    chk("status expire", 32'h0000_00a9, {24'h00_0000, status_out});
    exec(14'h0063, 8'h03, 8'hb1);
    chk("sleep_go", 32'h1, {31'h0, sleep_go});
    expire();
    chk("status expire", 32'h0000_00a1, {24'h00_0000, status_out});
    exec(14'h0064, 8'h03, 8'hb9);
    chk("wdt_clear", 32'h1, {31'h0, wdt_clear});
    $display("test watchdog done");

    // Non-flag instructions on an ordinary file keep the flags
    exec(14'h00a0, 8'h03, 8'hb9);
    chk("file_wr_en", 32'h1, {31'h0, file_wr_en});
    chk("file_wr_addr", 32'h0000_00a0, {23'h0, file_wr_addr});
    chk("file_wr_data", 32'h0000_0003, {24'h00_0000, file_wr_data});
    exec(14'h1420, 8'h03, 8'hb9);
    chk("file_wr_data", 32'h0000_0011, {24'h00_0000, file_wr_data});
    exec(14'h0e20, 8'h01, 8'hb9);
    chk("no file write", 32'h0, {31'h0, file_wr_en});
    $display("test file target done");
    test_done();
  end
endmodule : asfr_status_core_tb_top
